// ---- hdl/lar_cksum.sv ----
// Classic LIN checksum accumulator: end-around carry sum, inverted on output.
// Assumes clr and add are never high together; sum_o is combinational.
module lar_cksum (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic clr,
  input wire logic add,
  input wire logic [7:0] byte_i,
  output logic [7:0] sum_o
);
  lar_pkg::lar_ck_t q, d;
  logic [8:0] raw;
  logic [7:0] wrap;

  // Next sum and inverted checksum, including the byte being added
  always_comb begin
    raw = {1'b0, q.acc} + {1'b0, byte_i};
    wrap = raw[7:0] + {7'h00, raw[8]}; // Carry folds back
    d = q;
    if (clr) begin
      d.acc = 8'h00;
    end else if (add) begin
      d.acc = wrap;
    end
    sum_o = ~(add ? wrap : q.acc);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule // lar_cksum

// ---- hdl/lar_top.sv ----
// Live LED parameter readback over LIN diagnostic frames, with AXI4-Lite settings registers.
// Assumes a LIN layer that pulses frame_start after break and sync, then passes each byte, PID first.
module lar_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic frame_start,
  input wire lar_pkg::lar_byte_t rx,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  lar_pkg::lar_st_t q, d;
  logic ck_clr, ck_add, tx_take, rx_take;
  logic [7:0] ck_byte, ck_sum;

  // Byte merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb,
                                        input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r & mask;
  endfunction

  // Answer data byte at a position for the selected answer
  function automatic logic [7:0] rsp_byte(input lar_pkg::lar_st_t s, input logic [3:0] i);
    logic [7:0] b;
    b = lar_pkg::FILL_BYTE;
    if (i == lar_pkg::IDX_FIRST) begin
      b = {lar_pkg::ADDR_TOP, s.ctrl[5:0]}; // Address echo
    end else if (!s.sel) begin
      case (i) // Colors, diagonal terms, fade
        4'h1: b = s.color[7:0];
        4'h2: b = s.color[15:8];
        4'h3: b = s.color[23:16];
        4'h4: b = s.diag[7:0];
        4'h5: b = s.diag[15:8];
        4'h6: b = s.diag[23:16];
        4'h7: b = s.fade[7:0];
        default: b = lar_pkg::FILL_BYTE;
      endcase
    end else begin
      case (i) // Off-diagonal terms and flags
        4'h1: b = s.offd0[7:0];
        4'h2: b = s.offd0[15:8];
        4'h3: b = s.offd0[23:16];
        4'h4: b = s.offd0[31:24];
        4'h5: b = s.offd1[7:0];
        4'h6: b = s.offd1[15:8];
        4'h7: b = {s.ctrl[lar_pkg::CTRL_CAL_BIT], s.ctrl[lar_pkg::CTRL_FREQ_BIT], 1'b1,
                   s.ctrl[lar_pkg::CTRL_THERM_BIT], s.ctrl[lar_pkg::CTRL_GRP_LSB +: 4]};
        default: b = lar_pkg::FILL_BYTE;
      endcase
    end
    return b;
  endfunction

  lar_cksum u_cksum (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .clr(ck_clr),
    .add(ck_add),
    .byte_i(ck_byte),
    .sum_o(ck_sum)
  );

  // Handshakes and checksum feed
  always_comb begin
    tx_valid = (q.state == lar_pkg::ST_TX);
    tx_data = q.txd;
    tx_take = tx_valid && tx_ready && ce;
    rx_take = rx.valid && ce;
    ck_clr = frame_start;
    ck_add = !frame_start && ((tx_take && q.idx != lar_pkg::IDX_CK) ||
             (q.state == lar_pkg::ST_RX && rx.valid && q.idx != lar_pkg::IDX_CK));
    ck_byte = tx_valid ? q.txd : rx.data;
    // Bus handshakes close only while running, so a frozen block never loses an item
    s_axi_awready = !q.aw_have && !q.bvalid && ce;
    s_axi_wready = !q.w_have && !q.bvalid && ce;
    s_axi_bvalid = q.bvalid && ce;
    s_axi_bresp = q.bresp;
    s_axi_arready = !q.rvalid && ce;
    s_axi_rvalid = q.rvalid && ce;
    s_axi_rdata = q.rdata;
    s_axi_rresp = q.rresp;
  end

  // Frame handler and register file
  always_comb begin
    d = q;
    // LIN side
    if (frame_start) begin
      d.state = lar_pkg::ST_PID;
    end else begin
      case (q.state)
        lar_pkg::ST_PID: begin
          if (rx.valid) begin
            d.idx = lar_pkg::IDX_FIRST;
            d.pend = 1'b0; // One slot only per accepted request
            d.ok = 1'b1;
            if (rx.data == lar_pkg::REQ_PID) begin
              d.state = lar_pkg::ST_RX;
            end else if (rx.data == lar_pkg::RSP_PID && q.pend) begin
              d.state = lar_pkg::ST_TX; // Silent unless a matching request came
              d.txd = rsp_byte(q, lar_pkg::IDX_FIRST);
            end else begin
              d.state = lar_pkg::ST_IDLE;
            end
          end
        end
        lar_pkg::ST_RX: begin
          if (rx.valid) begin
            d.idx = q.idx + 4'h1;
            case (q.idx) // Request layout
              lar_pkg::IDX_FIRST: d.ok = q.ok && (rx.data == lar_pkg::APP_CMD);
              lar_pkg::IDX_CMD: begin
                d.ok = q.ok && rx.data[7] && (rx.data[6:0] == lar_pkg::CMD_RSP1 || rx.data[6:0] == lar_pkg::CMD_RSP2);
                d.sel = (rx.data[6:0] == lar_pkg::CMD_RSP2); // Code picks the answer
              end
              lar_pkg::IDX_ADDR: d.ok = q.ok && (rx.data == {lar_pkg::ADDR_TOP, q.ctrl[5:0]});
              lar_pkg::IDX_CK: begin
                d.pend = q.ok && (rx.data == ck_sum); // Checksum over data only
                d.state = lar_pkg::ST_IDLE;
              end
              default: d.ok = q.ok && (rx.data == lar_pkg::FILL_BYTE);
            endcase
          end
        end
        lar_pkg::ST_TX: begin
          if (tx_take) begin
            d.idx = q.idx + 4'h1;
            if (q.idx == lar_pkg::IDX_CK) begin
              d.state = lar_pkg::ST_IDLE;
              d.served = q.served + 8'h01;
            end else if (q.idx == lar_pkg::IDX_LAST) begin
              d.txd = ck_sum; // Checksum follows the eighth data byte
            end else begin
              d.txd = rsp_byte(q, q.idx + 4'h1);
            end
          end
        end
        default: d.state = lar_pkg::ST_IDLE;
      endcase
    end
    // Bus write: address and data in either order, answer after both
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.aw_have && q.w_have) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = lar_pkg::RESP_OKAY;
      case (q.aw_addr)
        lar_pkg::OFS_CTRL: d.ctrl = merge(q.ctrl, q.wdata, q.wstrb, lar_pkg::MASK_CTRL);
        lar_pkg::OFS_COLOR: d.color = merge(q.color, q.wdata, q.wstrb, lar_pkg::MASK_COLOR);
        lar_pkg::OFS_DIAG: d.diag = merge(q.diag, q.wdata, q.wstrb, lar_pkg::MASK_DIAG);
        lar_pkg::OFS_FADE: d.fade = merge(q.fade, q.wdata, q.wstrb, lar_pkg::MASK_FADE);
        lar_pkg::OFS_OFFD0: d.offd0 = merge(q.offd0, q.wdata, q.wstrb, lar_pkg::MASK_OFFD0);
        lar_pkg::OFS_OFFD1: d.offd1 = merge(q.offd1, q.wdata, q.wstrb, lar_pkg::MASK_OFFD1);
        lar_pkg::OFS_STAT: d.bresp = lar_pkg::RESP_OKAY;
        default: d.bresp = lar_pkg::RESP_SLVERR;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // Bus read
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = lar_pkg::RESP_OKAY;
      d.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        lar_pkg::OFS_CTRL: d.rdata = q.ctrl;
        lar_pkg::OFS_COLOR: d.rdata = q.color;
        lar_pkg::OFS_DIAG: d.rdata = q.diag;
        lar_pkg::OFS_FADE: d.rdata = q.fade;
        lar_pkg::OFS_OFFD0: d.rdata = q.offd0;
        lar_pkg::OFS_OFFD1: d.rdata = q.offd1;
        lar_pkg::OFS_STAT: begin
          d.rdata[lar_pkg::STAT_PEND_BIT] = q.pend;
          d.rdata[lar_pkg::STAT_SEL_BIT] = q.sel;
          d.rdata[lar_pkg::STAT_CNT_LSB +: 8] = q.served;
        end
        default: d.rresp = lar_pkg::RESP_SLVERR;
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.state <= lar_pkg::ST_IDLE;
      q.ctrl <= lar_pkg::RST_CTRL;
      q.color <= lar_pkg::RST_COLOR;
      q.diag <= lar_pkg::RST_DIAG;
      q.fade <= lar_pkg::RST_FADE;
      q.offd0 <= lar_pkg::RST_OFFD0;
      q.offd1 <= lar_pkg::RST_OFFD1;
    end else if (ce) begin
      q <= d;
    end
  end

  property p_addr_echo;
    @(posedge aclk) disable iff (!aresetn)
      (tx_valid && q.idx == 4'h0) |-> (tx_data[7:6] == 2'b11 && tx_data[5:0] == q.ctrl[5:0]);
  endproperty
  a_addr_echo: assert property (p_addr_echo) else $error("address echo wrong");

  property p_color1;
    @(posedge aclk) disable iff (!aresetn)
      (tx_take && q.idx == 4'h0 && !q.sel && !frame_start) |=> (tx_data == $past(q.color[7:0]));
  endproperty
  a_color1: assert property (p_color1) else $error("answer one byte two not color one");

  property p_flags;
    @(posedge aclk) disable iff (!aresetn)
      (tx_valid && q.idx == 4'h7 && q.sel) |-> (tx_data[5] && tx_data[3:0] == q.ctrl[11:8]);
  endproperty
  a_flags: assert property (p_flags) else $error("answer two flag byte wrong");

  property p_cksum_out;
    @(posedge aclk) disable iff (!aresetn)
      (tx_take && q.idx == 4'h7 && !frame_start) |=> (tx_valid && tx_data == ck_sum);
  endproperty
  a_cksum_out: assert property (p_cksum_out) else $error("checksum byte wrong");

  property p_sel_code;
    @(posedge aclk) disable iff (!aresetn)
      (q.state == lar_pkg::ST_RX && q.idx == 4'h1 && rx_take && !frame_start && rx.data == 8'h83)
        |=> q.sel;
  endproperty
  a_sel_code: assert property (p_sel_code) else $error("code 0x03 did not pick answer two");

  property p_silent;
    @(posedge aclk) disable iff (!aresetn)
      (q.state == lar_pkg::ST_PID && rx_take && !q.pend) |=> !tx_valid [*2];
  endproperty
  a_silent: assert property (p_silent) else $error("answer without accepted request");
endmodule // lar_top

// ---- pkg/lar_pkg.sv ----
// Constants and types of the live LED parameter readback handler.
// Assumes a LIN protocol layer that delivers header and data bytes and serialises answer bytes.
// How it works
// - Answer one sends address, colors 1-3, a11, a22, a33, fade on/slope/time.
// - Command code 0x02 selects answer one, code 0x03 selects answer two.
// - Answer two sends a12..a32, then cal, frequency, one, thermal, group bits.
// - Frames end with classic checksum; answer byte one is address with top ones.
package lar_pkg;
  // Frame identifiers and fixed request bytes
  localparam logic [7:0] REQ_PID = 8'h3C;
  localparam logic [7:0] RSP_PID = 8'h7D;
  localparam logic [7:0] APP_CMD = 8'h80;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [6:0] CMD_RSP1 = 7'h02;
  localparam logic [6:0] CMD_RSP2 = 7'h03;
  localparam logic [1:0] ADDR_TOP = 2'b11;
  // Byte positions inside the eight data bytes; position eight is the checksum
  localparam logic [3:0] IDX_FIRST = 4'h0;
  localparam logic [3:0] IDX_CMD = 4'h1;
  localparam logic [3:0] IDX_ADDR = 4'h2;
  localparam logic [3:0] IDX_LAST = 4'h7;
  localparam logic [3:0] IDX_CK = 4'h8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COLOR = 8'h04;
  localparam logic [7:0] OFS_DIAG = 8'h08;
  localparam logic [7:0] OFS_FADE = 8'h0C;
  localparam logic [7:0] OFS_OFFD0 = 8'h10;
  localparam logic [7:0] OFS_OFFD1 = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Implemented bits per register
  localparam logic [31:0] MASK_CTRL = 32'h0007_0F3F;
  localparam logic [31:0] MASK_COLOR = 32'h00FF_FFFF;
  localparam logic [31:0] MASK_DIAG = 32'h00FF_FFFF;
  localparam logic [31:0] MASK_FADE = 32'h0000_00FF;
  localparam logic [31:0] MASK_OFFD0 = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_OFFD1 = 32'h0000_FFFF;
  // Values after reset
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_COLOR = 32'h0000_0000;
  localparam logic [31:0] RST_DIAG = 32'h0000_0000;
  localparam logic [31:0] RST_FADE = 32'h0000_0000;
  localparam logic [31:0] RST_OFFD0 = 32'h0000_0000;
  localparam logic [31:0] RST_OFFD1 = 32'h0000_0000;
  // Field positions
  localparam int CTRL_GRP_LSB = 8;
  localparam int CTRL_CAL_BIT = 16;
  localparam int CTRL_FREQ_BIT = 17;
  localparam int CTRL_THERM_BIT = 18;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_SEL_BIT = 1;
  localparam int STAT_CNT_LSB = 8;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {ST_IDLE, ST_PID, ST_RX, ST_TX} lar_state_t;

  // One received byte with its strobe
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } lar_byte_t;

  typedef struct packed {
    logic [7:0] acc;
  } lar_ck_t;

  typedef struct packed {
    lar_state_t state;
    logic [3:0] idx;
    logic ok;
    logic sel;
    logic pend;
    logic [7:0] txd;
    logic [7:0] served;
    logic [31:0] ctrl;
    logic [31:0] color;
    logic [31:0] diag;
    logic [31:0] fade;
    logic [31:0] offd0;
    logic [31:0] offd1;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lar_st_t;
endpackage

// ---- sim/lar_lin_master.sv ----
// Behavioural LIN master: sends diagnostic request frames and collects in-frame answers.
// Assumes the handler samples rx and frame_start on the rising edge of aclk.
module lar_lin_master (
  input wire logic aclk,
  output logic frame_start,
  output lar_pkg::lar_byte_t rx,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet line at time zero
  initial begin
    frame_start = 1'b0;
    rx = '0;
    tx_ready = 1'b0;
  end
  // One byte strobe, then the data line shows the inverse so stale data never matches
  task automatic put(input logic [7:0] b);
    rx.valid <= 1'b1;
    rx.data <= b;
    @(posedge aclk);
    rx.valid <= 1'b0;
    rx.data <= ~b;
    @(posedge aclk);
  endtask
  // Break and sync marker, then one identifier byte
  task automatic head(input logic [7:0] pid);
    frame_start <= 1'b1;
    @(posedge aclk);
    frame_start <= 1'b0;
    put(pid);
  endtask
  // Master request frame: identifier, eight data bytes, checksum
  task automatic request(input logic [7:0] d [8], input logic [7:0] ck);
    head(lar_pkg::REQ_PID);
    foreach (d[i]) put(d[i]);
    put(ck);
  endtask
  // Answer slot: up to nine bytes, with optional stalls; n is zero for a silent slot
  task automatic answer(output logic [7:0] got [9], output int n);
    logic hs;
    n = 0;
    head(lar_pkg::RSP_PID);
    for (int t = 0; t < 60 && n < 9; t++) begin
      tx_ready <= slow ? t[0] : 1'b1;
      @(negedge aclk);
      hs = tx_valid === 1'b1 && tx_ready === 1'b1;
      if (hs) got[n] = tx_data;
      if (hs) n++;
      @(posedge aclk);
    end
    tx_ready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule // lar_lin_master

// ---- sim/lin_actual_param_readback_tb.sv ----
// Self-checking bench of the live LED parameter readback handler.
// Assumes lar_pkg and the partner model lar_lin_master are compiled first.
module lin_actual_param_readback_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, ce, frame_start, tx_valid, tx_ready, slow;
  lar_pkg::lar_byte_t rx;
  logic [7:0] tx_data, s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] regs [6];
  logic [7:0] served;
  logic sel_e;
  int num_errors, total_checks;
  lar_top DUT (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .frame_start(frame_start),
    .rx(rx),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready)
  );
  lar_lin_master m (
    .aclk(aclk),
    .frame_start(frame_start),
    .rx(rx),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready),
    .slow(slow)
  );
  // Clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) num_errors++;
    if (g !== e) $display("BAD t=%0t got=%h exp=%h", $time, g, e);
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Classic checksum: end-around carry sum of the data bytes, inverted
  function automatic logic [7:0] cks(input logic [7:0] b [8]);
    logic [8:0] s;
    s = '0;
    foreach (b[i]) s = {1'b0, s[7:0]} + {1'b0, b[i]} + {8'h00, s[8]};
    s = {1'b0, s[7:0]} + {8'h00, s[8]};
    return ~s[7:0];
  endfunction
  // AXI write: address and data offered together, bready held high throughout
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw, ta, tw, tb;
    pa = 1'b1;
    pw = 1'b1;
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!tb) begin
      @(negedge aclk);
      ta = pa && s_axi_awready === 1'b1;
      tw = pw && s_axi_wready === 1'b1;
      tb = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic pa, ta, done;
    pa = 1'b1;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(negedge aclk);
      ta = pa && s_axi_arready === 1'b1;
      done = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      pa = pa && !ta;
    end
  endtask
  // Random settings written, then read back against the implemented-bit masks
  task automatic prog();
    logic [31:0] msk [6];
    logic [31:0] v;
    msk = '{lar_pkg::MASK_CTRL, lar_pkg::MASK_COLOR, lar_pkg::MASK_DIAG,
            lar_pkg::MASK_FADE, lar_pkg::MASK_OFFD0, lar_pkg::MASK_OFFD1};
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      regs[i] = v & msk[i];
      wr(8'(4 * i), v);
      chk(32'(r), 32'(lar_pkg::RESP_OKAY));
      rd(8'(4 * i));
      chk(d, regs[i]);
      chk(32'(r), 32'(lar_pkg::RESP_OKAY));
    end
  endtask
  // Request frame; bad picks a corruption: 1 node, 2 checksum, 3 first byte, 4 command, 5 fill
  task automatic req(input logic s, input int bad);
    logic [7:0] q [8];
    q[0] = lar_pkg::APP_CMD;
    q[1] = {1'b1, s ? lar_pkg::CMD_RSP2 : lar_pkg::CMD_RSP1};
    q[2] = {2'b11, regs[0][5:0] ^ 6'(bad == 1)};
    for (int i = 3; i < 8; i++) q[i] = lar_pkg::FILL_BYTE;
    if (bad == 3) q[0] = 8'h81;
    if (bad == 4) q[1] = 8'h84;
    if (bad == 5) q[7] = 8'hFE;
    m.request(q, cks(q) ^ 8'(bad == 2));
  endtask
  // Expected answer bytes from the settings last written
  task automatic ans(input logic s, input logic live);
    logic [7:0] g [9];
    logic [7:0] q [8];
    int n;
    q[0] = {2'b11, regs[0][5:0]};
    for (int i = 0; i < 3; i++) q[1 + i] = s ? regs[4][8 * i +: 8] : regs[1][8 * i +: 8];
    q[4] = s ? regs[4][31:24] : regs[2][7:0];
    q[5] = s ? regs[5][7:0] : regs[2][15:8];
    q[6] = s ? regs[5][15:8] : regs[2][23:16];
    q[7] = s ? {regs[0][16], regs[0][17], 1'b1, regs[0][18], regs[0][11:8]} : regs[3][7:0];
    m.answer(g, n);
    chk(32'(n), live ? 32'd9 : 32'd0);
    for (int i = 0; i < n; i++) chk(32'(g[i]), i < 8 ? 32'(q[i]) : 32'(cks(q)));
    chk(32'(tx_valid), 32'd0);
    if (live) served++;
  endtask
  // Watchdog
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    close_out();
  end
  // Main sequence
  initial begin
    {aresetn, ce, slow, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 6'b010000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_bready, s_axi_rready, served, seed} = {10'h300, 32'h5C30};
    num_errors = 0;
    total_checks = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    s_axi_wstrb <= 4'hF;
    @(posedge aclk);
    // Every register reads its value after reset
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      chk(d, 32'h0);
      chk(32'(r), 32'(lar_pkg::RESP_OKAY));
    end
    wr(8'h1C, rnd());
    chk(32'(r), 32'(lar_pkg::RESP_SLVERR));
    rd(8'h1C);
    chk(32'(r), 32'(lar_pkg::RESP_SLVERR));
    wr(lar_pkg::OFS_STAT, 32'hFFFF_FFFF);
    rd(lar_pkg::OFS_STAT);
    chk(d, 32'h0);
    // One byte lane only
    s_axi_wstrb <= 4'h2;
    wr(lar_pkg::OFS_COLOR, 32'hFFFF_FFFF);
    s_axi_wstrb <= 4'hF;
    rd(lar_pkg::OFS_COLOR);
    chk(d, 32'h0000_FF00);
    // A write offered while the clock enable is low must wait for it
    ce <= 1'b0;
    fork
      wr(lar_pkg::OFS_FADE, 32'h0000_01A5);
      begin
        repeat (4) @(posedge aclk);
        ce <= 1'b1;
      end
    join
    rd(lar_pkg::OFS_FADE);
    chk(d, 32'h0000_00A5);
    for (int k = 0; k < 14; k++) begin
      logic s;
      s = 1'(rnd() >> 7);
      prog();
      slow <= 1'(rnd() >> 3);
      if (k != 13) req(s, k < 8 ? 0 : k - 7);
      // Command 0x04 selects answer one; no request keeps the last selection
      if (k != 13) sel_e = s && (k != 11);
      rd(lar_pkg::OFS_STAT);
      chk(d, {16'h0, served, 6'h0, sel_e, 1'(k < 8)});
      ans(s, k < 8);
    end
    close_out();
  end
endmodule // lin_actual_param_readback_tb
